/* rtl/hfsa_regs.vh */
// Purpose: constants for the short hex float adder
// Assumes: byte offsets on a 32-bit APB
// Notes: definitions only
`ifndef HFSA_REGS_VH
`define HFSA_REGS_VH
`define HFSA_OFF_CTRL 8'h00
`define HFSA_OFF_OPND 8'h04
`define HFSA_OFF_STAT 8'h08
`define HFSA_OFF_MASK 8'h0c
`define HFSA_OFF_COND 8'h10
`define HFSA_OFF_GRD 8'h14
`define HFSA_OFF_FLAG 8'h18
`define HFSA_OFF_FPR0 8'h20
`define HFSA_OFF_FPR1 8'h24
`define HFSA_OFF_FPR2 8'h28
`define HFSA_OFF_FPR3 8'h2c
`define HFSA_CTRL_START 0
`define HFSA_CTRL_UNNORM 1
`define HFSA_CTRL_CMP 2
`define HFSA_EV_DONE 0
`define HFSA_EV_SPEC 1
`define HFSA_EV_UFL 2
`define HFSA_EV_SIG 3
`define HFSA_EV_OFL 4
`define HFSA_EV_W 5
`define HFSA_RST_STAT 5'h00
`define HFSA_RST_MASK 5'h00
`define HFSA_RST_COND 4'h0
`define HFSA_RST_OPND 8'h00
`define HFSA_FPR_LIM 4'h8
`define HFSA_DBL_LIM 7'h0f
`define HFSA_SNG_LIM 7'h07
`define HFSA_LS_GUARD 8'h9a
`define HFSA_CC_ZERO 4'h8
`define HFSA_CC_NEG 4'h4
`define HFSA_CC_POS 4'h2
`endif

/* rtl/hfsa_adder.v */
// Purpose: byte-serial short hex floating-point add, register pair format
// Assumes: one clock pclk, APB slave, zero-wait answers
// Notes: four short floating-point registers live in flip-flops here
// Function
// - register numbers even and below 8
// - characteristic shifted left, sign bit kept
// - subtract characteristics, flag unequal and larger
// - difference range: double limit, then single
// - smaller characteristic aligned, bytes plus odd
// - high digit shifted out kept as guard
// - guard saved at storage 9A, true/complement
// - add fractions low byte first with carry
// - zero byte added after source bytes end
// - result to first operand, second unchanged
// - sign and carry detect overflow or recomplement
// - normalize only nonzero; zero is significance loss
// - per leading zero: decrement, write, shift
// - decrement carry one valid, zero underflow
// - guard into first vacated digit, then zeros
// - condition code set; positive nonzero 0010
// - clear flags and shift register at end
`timescale 1ns/1ns
`include "hfsa_regs.vh"
module hfsa_adder #(
  parameter ADDR_W = 8
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt
  output wire irq
);
  localparam S_IDLE = 4'd0;
  localparam S_CHK = 4'd1;
  localparam S_CHR = 4'd2;
  localparam S_DIF = 4'd3;
  localparam S_GRD = 4'd4;
  localparam S_ADD = 4'd5;
  localparam S_OVF = 4'd6;
  localparam S_NRM = 4'd7;
  localparam S_CC = 4'd8;
  localparam S_END = 4'd9;

  function [7:0] byte_of;
    input [23:0] w;
    input [1:0] i;
    begin
      byte_of = w[i*8 +: 8];
    end
  endfunction

  function mapped;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `HFSA_OFF_CTRL, `HFSA_OFF_OPND, `HFSA_OFF_STAT, `HFSA_OFF_MASK,
        `HFSA_OFF_COND, `HFSA_OFF_GRD, `HFSA_OFF_FLAG, `HFSA_OFF_FPR0,
        `HFSA_OFF_FPR1, `HFSA_OFF_FPR2, `HFSA_OFF_FPR3: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  reg [31:0] fpr [0:3];
  reg [7:0] opnd;
  reg unnorm;
  reg cmp_op;
  reg [4:0] status;
  reg [4:0] mask;
  reg [3:0] cond;
  reg [7:0] guard_ls;
  reg start;
  reg [3:0] state;
  reg [4:0] ev;
  reg dst_sign;
  reg src_sign;
  reg chr_ne;
  reg dst_larger;
  reg [6:0] chr_d;
  reg [6:0] chr_s;
  reg [6:0] res_chr;
  reg res_sign;
  reg eff_sub;
  reg [23:0] acc;
  reg [23:0] addend;
  reg [3:0] guard;
  reg carry;
  reg [1:0] bidx;
  reg [1:0] src_bytes;
  reg [1:0] whole_bytes;
  reg odd_shift;
  reg [7:0] shift_aux;
  reg [1:0] d_idx;
  reg [1:0] s_idx;

  wire acc_wr = psel & penable;
  wire wr = acc_wr & pwrite;
  wire busy = (state != S_IDLE);
  wire [3:0] r1 = opnd[7:4];
  wire [3:0] r2 = opnd[3:0];

  // Magnitude of the characteristic difference
  wire [6:0] mag = dst_larger ? (chr_d - chr_s) : (chr_s - chr_d);
  wire too_dbl = (mag > `HFSA_DBL_LIM);
  wire too_sng = (mag > `HFSA_SNG_LIM);
  // Equal characteristics keep the destination on top, so the source is aligned
  wire dst_top = dst_larger | ~chr_ne;
  wire [23:0] small_frac = dst_top ? fpr[s_idx][23:0] : fpr[d_idx][23:0];
  wire [23:0] big_frac = dst_top ? fpr[d_idx][23:0] : fpr[s_idx][23:0];
  wire [31:0] aligned = {small_frac, 8'h00} >> {mag[2:0], 2'b00};

  // Byte adder
  wire [7:0] src_b = (bidx < src_bytes) ? byte_of(addend, bidx) : 8'h00;
  wire [7:0] src_bx = eff_sub ? ~src_b : src_b;
  wire [8:0] bsum = {1'b0, byte_of(acc, bidx)} + {1'b0, src_bx} + {8'h00, carry};
  wire [23:0] acc_ins = (bidx == 2'd0) ? {acc[23:8], bsum[7:0]} :
                        (bidx == 2'd1) ? {acc[23:16], bsum[7:0], acc[7:0]} :
                        {bsum[7:0], acc[15:0]};
  wire [27:0] neg_frac = 28'h0 - {acc, guard};
  wire [7:0] chr_dec = {1'b0, res_chr} + 8'h7f;
  wire characteristic_carry_out = chr_dec[7];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign irq = |(status & mask);

  // APB registers and read path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd <= `HFSA_RST_OPND;
      unnorm <= 1'b0;
      cmp_op <= 1'b0;
      mask <= `HFSA_RST_MASK;
      status <= `HFSA_RST_STAT;
      start <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      start <= 1'b0;
      // Engine events win over a write-one clear in the same cycle
      if (wr && paddr == `HFSA_OFF_STAT)
        status <= (status & ~pwdata[4:0]) | ev;
      else
        status <= status | ev;
      if (wr && paddr == `HFSA_OFF_MASK)
        mask <= pwdata[4:0];
      if (wr && paddr == `HFSA_OFF_OPND && !busy)
        opnd <= pwdata[7:0];
      if (wr && paddr == `HFSA_OFF_CTRL && !busy) begin
        unnorm <= pwdata[`HFSA_CTRL_UNNORM];
        cmp_op <= pwdata[`HFSA_CTRL_CMP];
        start <= pwdata[`HFSA_CTRL_START];
      end
      if (psel && !penable) begin
        case (paddr)
          `HFSA_OFF_CTRL: prdata <= {29'h0, cmp_op, unnorm, busy};
          `HFSA_OFF_OPND: prdata <= {24'h0, opnd};
          `HFSA_OFF_STAT: prdata <= {27'h0, status};
          `HFSA_OFF_MASK: prdata <= {27'h0, mask};
          `HFSA_OFF_COND: prdata <= {28'h0, cond};
          `HFSA_OFF_GRD: prdata <= {24'h0, guard_ls};
          `HFSA_OFF_FLAG: prdata <= {16'h0, shift_aux, state, dst_sign, src_sign, chr_ne, dst_larger};
          `HFSA_OFF_FPR0: prdata <= fpr[0];
          `HFSA_OFF_FPR1: prdata <= fpr[1];
          `HFSA_OFF_FPR2: prdata <= fpr[2];
          `HFSA_OFF_FPR3: prdata <= fpr[3];
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Operation sequencer; software may load registers only while idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      ev <= 5'h00;
      fpr[0] <= 32'h00000000;
      fpr[1] <= 32'h00000000;
      fpr[2] <= 32'h00000000;
      fpr[3] <= 32'h00000000;
      cond <= `HFSA_RST_COND;
      guard_ls <= 8'h00;
      dst_sign <= 1'b0;
      src_sign <= 1'b0;
      chr_ne <= 1'b0;
      dst_larger <= 1'b0;
      chr_d <= 7'h00;
      chr_s <= 7'h00;
      res_chr <= 7'h00;
      res_sign <= 1'b0;
      eff_sub <= 1'b0;
      acc <= 24'h000000;
      addend <= 24'h000000;
      guard <= 4'h0;
      carry <= 1'b0;
      bidx <= 2'd0;
      src_bytes <= 2'd0;
      whole_bytes <= 2'd0;
      odd_shift <= 1'b0;
      shift_aux <= 8'h00;
      d_idx <= 2'd0;
      s_idx <= 2'd0;
    end else begin
      ev <= 5'h00;
      case (state)
        S_IDLE: begin
          if (wr && !paddr[ADDR_W-1] && paddr[5] && paddr[1:0] == 2'b00 &&
              paddr >= `HFSA_OFF_FPR0 && paddr <= `HFSA_OFF_FPR3)
            fpr[paddr[3:2]] <= pwdata;
          if (start)
            state <= S_CHK;
        end
        S_CHK: begin
          if (r1[0] || r2[0] || r1 >= `HFSA_FPR_LIM || r2 >= `HFSA_FPR_LIM) begin
            ev[`HFSA_EV_SPEC] <= 1'b1;
            state <= S_IDLE;
          end else begin
            d_idx <= r1[2:1];
            s_idx <= r2[2:1];
            state <= S_CHR;
          end
        end
        S_CHR: begin
          // sign taken from bit shifted out
          {src_sign, chr_s} <= fpr[s_idx][31:24];
          {dst_sign, chr_d} <= fpr[d_idx][31:24];
          chr_ne <= (fpr[d_idx][30:24] != fpr[s_idx][30:24]);
          dst_larger <= (fpr[d_idx][30:24] > fpr[s_idx][30:24]);
          state <= S_DIF;
        end
        S_DIF: begin
          // smaller characteristic is aligned; equal keeps destination on top
          acc <= big_frac;
          res_chr <= dst_top ? chr_d : chr_s;
          res_sign <= dst_top ? dst_sign : src_sign;
          eff_sub <= dst_sign ^ src_sign;
          whole_bytes <= mag[2:1];
          odd_shift <= mag[0];
          src_bytes <= 2'd3 - mag[2:1];
          if (too_dbl || too_sng) begin
            addend <= 24'h000000;
            guard <= 4'h0;
          end else begin
            addend <= aligned[31:8];
            guard <= aligned[7:4];
          end
          state <= S_GRD;
        end
        S_GRD: begin
          guard_ls <= {(eff_sub ? 4'h0 - guard : guard), 4'h0};
          guard <= eff_sub ? 4'h0 - guard : guard;
          // two's complement carry enters at guard
          carry <= eff_sub && (guard == 4'h0);
          shift_aux <= {6'h00, whole_bytes};
          bidx <= 2'd0;
          state <= S_ADD;
        end
        S_ADD: begin
          acc <= acc_ins;
          carry <= bsum[8];
          // only the first operand is written
          if (!cmp_op)
            fpr[d_idx] <= {res_sign, res_chr, acc_ins};
          if (bidx == 2'd2)
            state <= S_OVF;
          bidx <= bidx + 2'd1;
        end
        S_OVF: begin
          // carry and sign decide the fix-up
          if (eff_sub && !carry) begin
            {acc, guard} <= neg_frac;
            res_sign <= ~res_sign;
          end else if (!eff_sub && carry) begin
            {acc, guard} <= {4'h1, acc};
            res_chr <= res_chr + 7'h01;
            if (res_chr == 7'h7f)
              ev[`HFSA_EV_OFL] <= 1'b1;
          end
          state <= S_NRM;
        end
        S_NRM: begin
          // zero fraction is a significance loss
          if (acc == 24'h000000 && guard == 4'h0) begin
            ev[`HFSA_EV_SIG] <= 1'b1;
            res_chr <= 7'h00;
            res_sign <= 1'b0;
            state <= S_CC;
          end else if (unnorm || cmp_op || acc[23:20] != 4'h0) begin
            state <= S_CC;
          end else if (!characteristic_carry_out) begin
            // decrement carry of zero is underflow
            ev[`HFSA_EV_UFL] <= 1'b1;
            state <= S_CC;
          end else begin
            res_chr <= chr_dec[6:0];
            acc <= {acc[19:0], guard};
            guard <= 4'h0;
            fpr[d_idx] <= {res_sign, chr_dec[6:0], acc[19:0], guard};
          end
        end
        S_CC: begin
          if (!cmp_op)
            fpr[d_idx] <= {res_sign, res_chr, acc};
          if (acc == 24'h000000)
            cond <= `HFSA_CC_ZERO;
          else if (res_sign)
            cond <= `HFSA_CC_NEG;
          else
            cond <= `HFSA_CC_POS;
          state <= S_END;
        end
        S_END: begin
          dst_sign <= 1'b0;
          src_sign <= 1'b0;
          chr_ne <= 1'b0;
          dst_larger <= 1'b0;
          carry <= 1'b0;
          shift_aux <= 8'h00;
          ev[`HFSA_EV_DONE] <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // hfsa_adder

/* verif/hfsa_properties.sv */
// Purpose: port properties of the short hex float adder
// Assumes: sees only the top ports, zero-wait APB
// Notes: a mask shadow ties mask reads to earlier writes
`timescale 1ns/1ns
module hfsa_properties #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Interrupt
  input wire irq
);
  reg [4:0] last_mask;
  wire acc = psel && penable;
  wire unmapped = (paddr == 8'h1c) || (paddr > 8'h2c);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_mask <= 5'h00;
    end else if (acc && pwrite && paddr == 8'h0c) begin
      last_mask <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  err_unmapped_a: assert property (acc && unmapped |-> pslverr) else $error("no error on hole");
  err_mapped_a: assert property (acc && !unmapped && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped word");
  hole_zero_a: assert property (acc && !pwrite && paddr == 8'h1c |-> prdata == 32'h0)
    else $error("hole read not zero");
  rdata_hold_a: assert property (!psel |=> $stable(prdata)) else $error("prdata moved idle");
  mask_read_a: assert property (acc && !pwrite && paddr == 8'h0c |-> prdata[4:0] == last_mask)
    else $error("mask readback wrong");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc && pwrite)) else $error("irq fell unprompted");
endmodule // hfsa_properties

/* verif/hfsa_host.sv */
// Purpose: APB master standing for software
// Assumes: zero or more wait states, one clock
// Notes: signals change only by NBA after a rising edge
`timescale 1ns/1ns
module hfsa_host (
  // Clock
  input wire pclk,
  // APB
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [7:0] paddr,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] rdv, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the bench watchdog ends a wait for a dead slave
      while (pready !== 1'b1)
        @(posedge pclk);
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule // hfsa_host

/* verif/tb_top.sv */
// Purpose: self-checking bench for the short hex float adder
// Assumes: seed 90, equal characteristics for random adds
// Notes: expected sums for random adds come from a bench reference function
`timescale 1ns/1ns
`include "hfsa_regs.vh"
module tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, irq;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  integer miscompares = 0;
  integer checks = 0;
  integer seed = 90;
  integer i, n;
  reg [31:0] rv, a, b;
  reg e;
  reg [31:0] ctl = 32'h1;
  always #2 pclk = ~pclk;
  hfsa_adder #(.ADDR_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  hfsa_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Only valid when characteristics are equal, so no guard digit
  function [31:0] ref_add(input [31:0] d, input [31:0] s);
    reg [24:0] f;
    reg [6:0] c;
    reg sg;
    integer k;
    begin
      c = d[30:24];
      sg = d[31];
      if (d[31] == s[31]) f = d[23:0] + s[23:0];
      else if (d[23:0] >= s[23:0]) f = d[23:0] - s[23:0];
      else begin
        f = s[23:0] - d[23:0];
        sg = ~sg;
      end
      if (f[24]) begin
        f = f >> 4;
        c = c + 7'h01;
      end
      for (k = 0; k < 6; k = k + 1) if (f != 0 && f[23:20] == 4'h0) begin
        f = f << 4;
        c = c - 7'h01;
      end
      ref_add = (f == 0) ? 32'h0 : {sg, c, f[23:0]};
    end
  endfunction
  function [3:0] ref_cc(input [31:0] r);
    ref_cc = (r == 32'h0) ? `HFSA_CC_ZERO : (r[31] ? `HFSA_CC_NEG : `HFSA_CC_POS);
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] ad, input [31:0] d);
    u_host.xfer(1'b1, ad, d, rv, e);
  endtask
  task rd(input [7:0] ad);
    u_host.xfer(1'b0, ad, 32'h0, rv, e);
  endtask
  task run(input [7:0] op, input [31:0] d, input [31:0] s);
    begin
      wr(`HFSA_OFF_FPR0, d);
      wr(`HFSA_OFF_FPR1, s);
      wr(`HFSA_OFF_OPND, {24'h0, op});
      wr(`HFSA_OFF_CTRL, ctl);
      n = 0;
      rv = 32'h0;
      while (rv[0] !== 1'b1 && rv[1] !== 1'b1 && n < 200) begin
        rd(`HFSA_OFF_STAT);
        n = n + 1;
      end
      chk(n < 200, 32'h1);
    end
  endtask
  task add(input [31:0] d, input [31:0] s, input [31:0] ex);
    begin
      run(8'h02, d, s);
      chk(rv[1:0], 32'h1);
      rd(`HFSA_OFF_FPR0);
      chk(rv, ex);
      rd(`HFSA_OFF_FPR1);
      chk(rv, s);
      rd(`HFSA_OFF_COND);
      chk(rv[3:0], ref_cc(ex));
      rd(`HFSA_OFF_FLAG);
      chk(rv[15:0], 32'h0);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`HFSA_OFF_STAT);
    chk(rv, 32'h0);
    rd(`HFSA_OFF_MASK);
    chk(rv, 32'h0);
    rd(`HFSA_OFF_OPND);
    chk(rv, 32'h0);
    rd(8'h1c);
    chk(rv, 32'h0);
    chk(e, 32'h1);
    wr(`HFSA_OFF_MASK, 32'h1);
    add(32'h7a0b3862, 32'h7842e5d0, 32'h79b7b47d);
    rd(`HFSA_OFF_GRD);
    chk(rv[7:4], 32'hd);
    @(negedge pclk);
    chk(irq, 32'h1);
    wr(`HFSA_OFF_STAT, 32'h1f);
    @(negedge pclk);
    chk(irq, 32'h0);
    wr(`HFSA_OFF_MASK, 32'h0);
    add(32'h41300000, 32'hc1300000, 32'h0);
    @(negedge pclk);
    chk(irq, 32'h0);
    wr(`HFSA_OFF_STAT, 32'h1f);
    for (i = 0; i < 3; i = i + 1) begin
      run(i == 0 ? 8'h12 : (i == 1 ? 8'h80 : 8'h0a), 32'h41100000, 32'h41200000);
      chk(rv[1], 32'h1);
      rd(`HFSA_OFF_FPR0);
      chk(rv, 32'h41100000);
      wr(`HFSA_OFF_STAT, 32'h1f);
    end
    // Compare writes nothing back but sets the condition code
    ctl = 32'h5;
    run(8'h02, 32'h41100000, 32'h41200000);
    chk(rv[1:0], 32'h1);
    rd(`HFSA_OFF_FPR0);
    chk(rv, 32'h41100000);
    rd(`HFSA_OFF_COND);
    chk(rv[3:0], `HFSA_CC_POS);
    wr(`HFSA_OFF_STAT, 32'h1f);
    // Unnormalized add keeps the leading zero digit
    ctl = 32'h3;
    run(8'h02, 32'h41100000, 32'hc1080000);
    chk(rv[1:0], 32'h1);
    rd(`HFSA_OFF_FPR0);
    chk(rv, 32'h41080000);
    wr(`HFSA_OFF_STAT, 32'h1f);
    ctl = 32'h1;
    // Random signs exercise overflow, recomplement and normalize
    for (i = 0; i < 12; i = i + 1) begin
      a = $random(seed);
      b = $random(seed);
      a[30:27] = 4'b1000;
      a[20] = 1'b1;
      b[30:24] = a[30:24];
      b[20] = 1'b1;
      add(a, b, ref_add(a, b));
      wr(`HFSA_OFF_STAT, 32'h1f);
    end
    wrap_up;
  end
endmodule // tb_top
bind hfsa_adder hfsa_properties #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));
